//--- core/vapotg_regs.sv
// register bank: minimum voltage protection byte and reverse power voltage setpoint
`timescale 1ns/1ps
`default_nettype none

// Function
// - protect byte bits 7:2 hold six-bit alert threshold, weights 3200 down to 100 mV.
// - threshold resets per cell strap: 2-4 cells 0x6C, one cell 0x04.
// - tracking bit 1 makes level two follow level one; resets disabled.
// - bit 0 enables fast role swap; resets to zero.
// - fast swap enable rising edge blanks power stage about 50 us.
// - high impedance enable forces fast swap enable to zero.
// - setpoint is 12 bits at 13:2, 8 mV per step.
// - setpoint register resets to 09C4h.
// - during reverse power the applied setpoint is clamped to 3 V..24 V.
// - setpoint writes outside 3 V..24 V are discarded, old value kept.
// - bits 15:14 must be zero; a write setting them is invalid.
// - bits 1:0 are ignored on write and read as zero.
// - alert threshold equals 3.2 V plus weights of set bits.
// - one cell uses only the low three threshold bits.
module vapotg_regs (
   input  wire logic                    clk_sys,
   input  wire logic                    reset_n,
   input  wire vapotg_pkg::vapotg_req_t host_req,
   input  wire logic                    multi_cell,
   input  wire logic                    high_impedance_enable,
   input  wire logic                    otg_active,
   input  wire logic [5:0]              sys_alert_level_one,
   output var  logic [7:0]              rd_data_r,
   output var  logic                    rd_valid_r,
   output var  logic                    write_invalid_r,
   output var  logic [11:0]             setpoint_code_r,
   output var  logic [13:0]             sys_alert_level_two_mv_r,
   output var  logic                    fast_swap_enable_r,
   output var  logic                    power_stage_off_r
);

   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   function automatic logic code_in_range(input logic [11:0] code);
      return (code >= vapotg_pkg::SETPT_MIN_CODE) && (code <= vapotg_pkg::SETPT_MAX_CODE);
   endfunction

   function automatic logic [11:0] clamp_code(input logic [11:0] code);
      if (code < vapotg_pkg::SETPT_MIN_CODE) begin
         return vapotg_pkg::SETPT_MIN_CODE;
      end else if (code > vapotg_pkg::SETPT_MAX_CODE) begin
         return vapotg_pkg::SETPT_MAX_CODE;
      end
      return code;
   endfunction

   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   logic [7:0]  protect_r;
   logic [7:0]  protect_nxt;
   logic [15:0] setpt_r;
   logic [15:0] setpt_nxt;
   logic [7:0]  lo_stage_r;
   logic [7:0]  lo_stage_nxt;
   logic        init_done_r;

   // -------------------------------------------------------------
   // decode
   // -------------------------------------------------------------
   wire         wr_protect  = host_req.wr_en && host_req.addr == vapotg_pkg::ADDR_PROTECT;
   wire         wr_lo       = host_req.wr_en && host_req.addr == vapotg_pkg::ADDR_SETPT_LO;
   wire         wr_hi       = host_req.wr_en && host_req.addr == vapotg_pkg::ADDR_SETPT_HI;
   wire [15:0]  wr_word     = {host_req.data, lo_stage_r};
   wire [11:0]  wr_code     = wr_word[vapotg_pkg::SETPT_HI:vapotg_pkg::SETPT_LO];
   wire         rsv_clear   = wr_word[vapotg_pkg::RSV_HI:vapotg_pkg::RSV_LO]
                              == vapotg_pkg::RSV_ZERO;
   wire         hi_valid    = rsv_clear && code_in_range(wr_code);
   wire [11:0]  stored_code = setpt_r[vapotg_pkg::SETPT_HI:vapotg_pkg::SETPT_LO];
   wire [7:0]   strap_value = multi_cell ? vapotg_pkg::PROTECT_RESET_MULTI
                                         : vapotg_pkg::PROTECT_RESET_ONE;

   // -------------------------------------------------------------
   // protection byte
   // -------------------------------------------------------------
   // the strap is caught on the first edge after release, never by the async reset
   wire [7:0]   protect_wr  = wr_protect ? host_req.data : protect_r;
   wire [7:0]   protect_src = init_done_r ? protect_wr : strap_value;
   assign protect_nxt = {protect_src[7:1],
                         protect_src[vapotg_pkg::FSWAP_BIT] & ~high_impedance_enable};

   // -------------------------------------------------------------
   // setpoint: low byte staged, whole word applied on the high byte
   // -------------------------------------------------------------
   assign lo_stage_nxt = wr_lo ? host_req.data : lo_stage_r;
   assign setpt_nxt    = (wr_hi && hi_valid)
                         ? {vapotg_pkg::RSV_ZERO, wr_code, vapotg_pkg::LOW_BITS_ZERO}
                         : setpt_r;

   // -------------------------------------------------------------
   // derived outputs
   // -------------------------------------------------------------
   wire [5:0]   level_two_raw  = protect_r[vapotg_pkg::TRACK_BIT]
                                 ? sys_alert_level_one
                                 : protect_r[vapotg_pkg::TH_HI:vapotg_pkg::TH_LO];
   wire [5:0]   level_two_code = multi_cell ? level_two_raw
                                            : (level_two_raw & vapotg_pkg::ONE_CELL_MASK);
   wire [13:0]  level_two_mv   = vapotg_pkg::ALERT_OFFSET_MV
                                 + 14'(level_two_code) * vapotg_pkg::ALERT_STEP_MV;
   wire [11:0]  applied_code   = otg_active ? clamp_code(stored_code) : stored_code;
   wire         swap_start     = protect_r[vapotg_pkg::FSWAP_BIT] & ~fast_swap_enable_r;

   wire [7:0]   rd_mux = (host_req.addr == vapotg_pkg::ADDR_PROTECT)  ? protect_r :
                         (host_req.addr == vapotg_pkg::ADDR_SETPT_LO) ? setpt_r[7:0] :
                         (host_req.addr == vapotg_pkg::ADDR_SETPT_HI) ? setpt_r[15:8] :
                         8'h00;

   // -------------------------------------------------------------
   // registers
   // -------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         init_done_r <= 1'b0;
         protect_r   <= vapotg_pkg::PROTECT_RESET_ONE;
         setpt_r     <= vapotg_pkg::SETPT_RESET;
         lo_stage_r  <= vapotg_pkg::SETPT_RESET[7:0];
      end else begin
         init_done_r <= 1'b1;
         protect_r   <= protect_nxt;
         setpt_r     <= setpt_nxt;
         lo_stage_r  <= lo_stage_nxt;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rd_data_r                <= 8'h00;
         rd_valid_r               <= 1'b0;
         write_invalid_r          <= 1'b0;
         setpoint_code_r          <= vapotg_pkg::SETPT_RESET[13:2];
         sys_alert_level_two_mv_r <= vapotg_pkg::ALERT_OFFSET_MV;
         fast_swap_enable_r       <= 1'b0;
      end else begin
         rd_data_r                <= host_req.rd_en ? rd_mux : rd_data_r;
         rd_valid_r               <= host_req.rd_en;
         write_invalid_r          <= wr_hi && !hi_valid;
         setpoint_code_r          <= applied_code;
         sys_alert_level_two_mv_r <= level_two_mv;
         fast_swap_enable_r       <= protect_r[vapotg_pkg::FSWAP_BIT];
      end
   end

   vapotg_blank_timer u_blank (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .start   (swap_start),
      .busy_r  (power_stage_off_r)
   );

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   localparam logic [11:0] MIN_C = vapotg_pkg::SETPT_MIN_CODE;
   localparam logic [11:0] MAX_C = vapotg_pkg::SETPT_MAX_CODE;

   chk_rsv_bits_reject: assert property (@(posedge clk_sys) disable iff (!reset_n)
      wr_hi && host_req.data[7:6] != 2'h0 |=> $stable(setpt_r) && write_invalid_r)
      else $error("write with reserved bits set was applied");

   chk_range_reject: assert property (@(posedge clk_sys) disable iff (!reset_n)
      wr_hi && (wr_code < MIN_C || wr_code > MAX_C) |=> $stable(setpt_r))
      else $error("out of range setpoint was stored");

   chk_valid_apply: assert property (@(posedge clk_sys) disable iff (!reset_n)
      wr_hi && hi_valid |=> setpt_r[13:2] == $past(wr_code) && setpt_r[15:14] == 2'h0)
      else $error("valid setpoint word not applied");

   chk_low_bits_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
      setpt_r[1:0] == 2'h0)
      else $error("ignored setpoint bits hold a value");

   chk_hiz_forces: assert property (@(posedge clk_sys) disable iff (!reset_n)
      high_impedance_enable |=> !protect_r[0] ##1 !fast_swap_enable_r)
      else $error("fast swap survived high impedance mode");

   chk_swap_blank: assert property (@(posedge clk_sys) disable iff (!reset_n)
      $rose(fast_swap_enable_r) |-> power_stage_off_r)
      else $error("no blanking on fast swap enable edge");

   chk_clamp_range: assert property (@(posedge clk_sys) disable iff (!reset_n)
      otg_active |=> setpoint_code_r >= MIN_C && setpoint_code_r <= MAX_C)
      else $error("applied setpoint outside clamp");

   chk_one_cell_cap: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !multi_cell |=> sys_alert_level_two_mv_r <= vapotg_pkg::ALERT_ONE_CELL_MAX)
      else $error("one cell alert above cap");

   chk_strap_load: assert property (@(posedge clk_sys) disable iff (!reset_n)
      $rose(init_done_r) |-> protect_r == ($past(multi_cell) ? 8'h6C : 8'h04))
      else $error("protect byte not loaded from strap");

   chk_track_follow: assert property (@(posedge clk_sys) disable iff (!reset_n)
      protect_r[1] && multi_cell |=> sys_alert_level_two_mv_r
         == 14'h0C80 + 14'($past(sys_alert_level_one)) * 14'h0064)
      else $error("level two does not follow level one");

   chk_protect_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
      wr_protect && init_done_r && !high_impedance_enable |=> protect_r == $past(host_req.data))
      else $error("protect byte write not stored");

   // a staged low byte alone must never move the applied setpoint
   chk_lo_staged: assert property (@(posedge clk_sys) disable iff (!reset_n)
      wr_lo |=> $stable(setpt_r))
      else $error("low byte write changed the setpoint");

   cov_valid_write: cover property (@(posedge clk_sys) disable iff (!reset_n)
      wr_lo ##[1:4] (wr_hi && hi_valid));
   cov_invalid_write: cover property (@(posedge clk_sys) disable iff (!reset_n)
      wr_hi && !hi_valid);
   cov_swap_blank: cover property (@(posedge clk_sys) disable iff (!reset_n)
      $rose(power_stage_off_r));
   cov_hiz_blocks: cover property (@(posedge clk_sys) disable iff (!reset_n)
      high_impedance_enable && wr_protect && host_req.data[vapotg_pkg::FSWAP_BIT]);

endmodule

`default_nettype wire

//--- core/vapotg_pkg.sv
// package: register map, field layout and timing constants of the protection and setpoint bank
package vapotg_pkg;

   // -------------------------------------------------------------
   // register addresses
   // -------------------------------------------------------------
   localparam logic [7:0]  ADDR_SETPT_LO       = 8'h06;
   localparam logic [7:0]  ADDR_SETPT_HI       = 8'h07;
   localparam logic [7:0]  ADDR_PROTECT        = 8'h3E;

   // -------------------------------------------------------------
   // reset values
   // -------------------------------------------------------------
   localparam logic [15:0] SETPT_RESET         = 16'h09C4;
   localparam logic [7:0]  PROTECT_RESET_ONE   = 8'h04;
   localparam logic [7:0]  PROTECT_RESET_MULTI = 8'h6C;

   // -------------------------------------------------------------
   // field layout
   // -------------------------------------------------------------
   localparam int          TH_HI               = 7;
   localparam int          TH_LO               = 2;
   localparam int          TRACK_BIT           = 1;
   localparam int          FSWAP_BIT           = 0;
   localparam int          SETPT_HI            = 13;
   localparam int          SETPT_LO            = 2;
   localparam int          RSV_HI              = 15;
   localparam int          RSV_LO              = 14;
   localparam logic [1:0]  RSV_ZERO            = 2'h0;
   localparam logic [1:0]  LOW_BITS_ZERO       = 2'h0;
   localparam logic [5:0]  ONE_CELL_MASK       = 6'h07;

   // -------------------------------------------------------------
   // voltage scaling
   // -------------------------------------------------------------
   localparam int          SETPT_LSB_MV        = 8;
   localparam int          SETPT_MIN_MV        = 3000;
   localparam int          SETPT_MAX_MV        = 24000;
   localparam logic [11:0] SETPT_MIN_CODE      = 12'(SETPT_MIN_MV / SETPT_LSB_MV);
   localparam logic [11:0] SETPT_MAX_CODE      = 12'(SETPT_MAX_MV / SETPT_LSB_MV);
   localparam logic [13:0] ALERT_OFFSET_MV     = 14'h0C80;
   localparam logic [13:0] ALERT_STEP_MV       = 14'h0064;
   localparam logic [13:0] ALERT_ONE_CELL_MAX  = 14'h0F3C;

   // -------------------------------------------------------------
   // timing
   // -------------------------------------------------------------
   localparam int          CLK_PERIOD_NS       = 50;
   localparam int          BLANK_US            = 50;
   localparam int          BLANK_CYCLES        = (BLANK_US * 1000) / CLK_PERIOD_NS;
   localparam int          BLANK_W             = 10;

   // -------------------------------------------------------------
   // byte register access from the serial engine
   // -------------------------------------------------------------
   typedef struct packed {
      logic       wr_en;
      logic       rd_en;
      logic [7:0] addr;
      logic [7:0] data;
   } vapotg_req_t;

endpackage

//--- core/vapotg_blank_timer.sv
// power stage blanking timer started by a fast swap enable edge
`timescale 1ns/1ps
`default_nettype none

module vapotg_blank_timer (
   input  wire logic clk_sys,
   input  wire logic reset_n,
   input  wire logic start,
   output var  logic busy_r
);

   localparam int                       BLANK_LEN = vapotg_pkg::BLANK_CYCLES;
   localparam int                       BW        = vapotg_pkg::BLANK_W;
   localparam logic [BW-1:0]            LOAD      = BW'(BLANK_LEN - 1);
   localparam logic [vapotg_pkg::BLANK_W-1:0] ZERO = '0;

   logic [vapotg_pkg::BLANK_W-1:0] cnt_r;
   logic [vapotg_pkg::BLANK_W-1:0] cnt_nxt;
   logic                           busy_nxt;

   // a new edge while blanking restarts the full interval
   assign cnt_nxt  = start ? LOAD : (cnt_r != ZERO ? cnt_r - 1'b1 : ZERO);
   assign busy_nxt = start | (cnt_r != ZERO);

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r  <= '0;
         busy_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         busy_r <= busy_nxt;
      end
   end

   chk_blank_ends: assert property (@(posedge clk_sys) disable iff (!reset_n)
      $rose(busy_r) && !start |-> ##[1:BLANK_LEN] !busy_r)
      else $error("blanking lasted beyond its interval");

   chk_blank_min: assert property (@(posedge clk_sys) disable iff (!reset_n)
      $rose(busy_r) |-> busy_r [*8])
      else $error("blanking ended too early");

endmodule

`default_nettype wire

//--- verification/vapotg_host_model.sv
// host side model: byte strobe register accesses as delivered by the serial engine
`timescale 1ns/1ps
`default_nettype none

module vapotg_host_model (
   input  wire logic                    clk_sys,
   input  wire logic [7:0]              rd_data_r,
   input  wire logic                    rd_valid_r,
   output var  vapotg_pkg::vapotg_req_t host_req
);
   initial host_req = '0;

   // ----------------------------------------------------------------
   // accesses
   // ----------------------------------------------------------------
   // strobe dropped for a cycle after each access so it never changes twice at one time step
   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      host_req = '{wr_en: 1'b1, rd_en: 1'b0, addr: addr, data: data};
      @(negedge clk_sys);
      host_req = '0;
      @(negedge clk_sys);
   endtask

   task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic vld);
      host_req = '{wr_en: 1'b0, rd_en: 1'b1, addr: addr, data: 8'h00};
      @(negedge clk_sys);
      host_req = '0;
      data = rd_data_r;
      vld  = rd_valid_r;
      @(negedge clk_sys);
   endtask

   // reserved top bits stay as the caller gives them: only the setpoint write test leaves them random, on every fifth write after the four boundary writes
   task automatic wr16(input logic [15:0] val);
      wr(vapotg_pkg::ADDR_SETPT_LO, val[7:0]);
      wr(vapotg_pkg::ADDR_SETPT_HI, val[15:8]);
   endtask
endmodule

`default_nettype wire

//--- verification/vapotg_regs_tb.sv
// self-checking bench of the protection byte and reverse power setpoint bank
`timescale 1ns/1ps
`default_nettype none

module vapotg_regs_tb;
   logic                    clk_sys;
   logic                    reset_n;
   logic                    multi_cell;
   logic                    high_impedance_enable;
   logic                    otg_active;
   logic [5:0]              sys_alert_level_one;
   vapotg_pkg::vapotg_req_t host_req;
   logic [7:0]              rd_data_r;
   logic                    rd_valid_r;
   logic                    write_invalid_r;
   logic [11:0]             setpoint_code_r;
   logic [13:0]             sys_alert_level_two_mv_r;
   logic                    fast_swap_enable_r;
   logic                    power_stage_off_r;
   int                      num_errors;
   int                      samples_checked;
   int                      cycles;
   int                      inv_seen;
   int                      inv_exp;
   int                      setpt_m;
   int                      code;
   int                      n;
   int                      seed;
   logic [31:0]             v;
   logic [15:0]             w;
   logic [7:0]              b;
   logic [7:0]              rb;
   logic                    vld;
   int                      bnd [4] = '{374, 375, 3000, 3001};

   vapotg_regs DUT (.clk_sys(clk_sys), .reset_n(reset_n), .host_req(host_req),
      .multi_cell(multi_cell), .high_impedance_enable(high_impedance_enable),
      .otg_active(otg_active), .sys_alert_level_one(sys_alert_level_one),
      .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r), .write_invalid_r(write_invalid_r),
      .setpoint_code_r(setpoint_code_r), .sys_alert_level_two_mv_r(sys_alert_level_two_mv_r),
      .fast_swap_enable_r(fast_swap_enable_r), .power_stage_off_r(power_stage_off_r));

   vapotg_host_model host (.clk_sys(clk_sys), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
      .host_req(host_req));

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   // ----------------------------------------------------------------
   // checking helpers
   // ----------------------------------------------------------------
   always @(negedge clk_sys) if (write_invalid_r === 1'b1) inv_seen++;

   // a hang is cut short well past the longest test (one blanking interval plus register traffic)
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         $display("Error timeout expected 0 seen %0d", cycles);
         end_sim();
      end
   end

   task automatic end_sim();
      $display("checked %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic rdchk(input logic [7:0] addr, input logic [7:0] exp);
      host.rd(addr, rb, vld);
      chk("rd_valid_r", 16'h0001, {15'h0000, vld});
      chk("rd_data_r", {8'h00, exp}, {8'h00, rb});
   endtask

   task automatic do_reset(input logic mc);
      reset_n    = 1'b0;
      multi_cell = mc;
      repeat (12) @(negedge clk_sys);
      reset_n = 1'b1;
      setpt_m = 16'h09C4;
      repeat (3) @(negedge clk_sys);
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      {reset_n, multi_cell, high_impedance_enable, otg_active} = 4'h0;
      sys_alert_level_one = 6'h00;
      {num_errors, samples_checked, cycles, inv_seen, inv_exp} = '0;
      seed = 32'h0dc595ab;
      @(negedge clk_sys);
      do_reset(1'b1);
      rdchk(8'h06, 8'hC4);
      rdchk(8'h07, 8'h09);
      rdchk(8'h3E, 8'h6C);
      rdchk(8'h10, 8'h00);
      chk("alert", 16'd5900, 16'(sys_alert_level_two_mv_r));
      chk("setpoint", 16'h0271, 16'(setpoint_code_r));
      $display("test reset values done");
      for (int i = 0; i < 28; i++) begin
         v = $random(seed);
         w = v[15:0];
         if (i < 4) w = {2'b00, 12'(bnd[i]), v[1:0]};
         else if (i % 5 != 0) w[15:14] = 2'b00;
         otg_active = v[16];
         code = int'(w[13:2]);
         if (w[15:14] != 2'b00 || code < 375 || code > 3000) inv_exp++;
         else setpt_m = code * 4;
         host.wr16(w);
         chk("write_invalid_r", 16'(inv_exp), 16'(inv_seen));
         chk("setpoint_code_r", 16'(setpt_m / 4), 16'(setpoint_code_r));
         rdchk(8'h06, 8'(setpt_m));
         rdchk(8'h07, 8'(setpt_m / 256));
      end
      $display("test setpoint writes done");
      for (int i = 0; i < 16; i++) begin
         v = $random(seed);
         b = {v[7:1], 1'b0};
         sys_alert_level_one = v[13:8];
         multi_cell = v[14];
         host.wr(8'h3E, b);
         code = b[1] ? int'(v[13:8]) : int'(b[7:2]);
         if (!v[14]) code = code % 8;
         chk("alert", 16'(3200 + 100 * code), 16'(sys_alert_level_two_mv_r));
         rdchk(8'h3E, b);
      end
      $display("test alert threshold done");
      host.wr(8'h3E, 8'h01);
      chk("fast_swap_enable_r", 16'h0001, 16'(fast_swap_enable_r));
      n = 0;
      while (power_stage_off_r === 1'b1 && n < 2000) begin
         n++;
         @(negedge clk_sys);
      end
      chk("blank cycles", 16'(vapotg_pkg::BLANK_CYCLES), 16'(n));
      high_impedance_enable = 1'b1;
      repeat (3) @(negedge clk_sys);
      chk("fast_swap_enable_r", 16'h0000, 16'(fast_swap_enable_r));
      rdchk(8'h3E, 8'h00);
      host.wr(8'h3E, 8'h01);
      chk("power_stage_off_r", 16'h0000, 16'(power_stage_off_r));
      high_impedance_enable = 1'b0;
      $display("test fast swap done");
      do_reset(1'b0);
      rdchk(8'h3E, 8'h04);
      chk("alert", 16'd3300, 16'(sys_alert_level_two_mv_r));
      rdchk(8'h06, 8'hC4);
      $display("test one cell reset done");
      end_sim();
   end
endmodule

`default_nettype wire
